/* verilog/rfe_defines.svh */
// Purpose: Offsets, bit positions, reset values and vectors of the
//          read and fill error logging block.
// Assumes: One aligned 32-bit word per register on APB.
// Notes:   Definitions only.
`ifndef RFE_DEFINES_SVH
`define RFE_DEFINES_SVH

`define RFE_ADDR_W 32
`define RFE_SYN_W 8
`define RFE_PC_W 32
`define RFE_PADDR_W 8

`define RFE_OFF_STATUS 8'h00
`define RFE_OFF_FADDR 8'h04
`define RFE_OFF_FSYN 8'h08
`define RFE_OFF_PCS 8'h0C
`define RFE_OFF_CTRL 8'h10
`define RFE_OFF_FRPC 8'h14
`define RFE_OFF_SVPC 8'h18

`define RFE_B_RDHERR 0
`define RFE_B_TPAR 1
`define RFE_B_TCPAR 2
`define RFE_B_CACK 3
`define RFE_B_ISTR 4
`define RFE_B_BUS_SEO 7
`define RFE_B_FILL_VAL 8
`define RFE_B_FILL_UNC 9
`define RFE_B_FILL_RD 10
`define RFE_B_FILL_SECOND_ERROR_FLAG 14
`define RFE_B_WR_LOST 20

`define RFE_B_PAGE_ENTRY_READ_ERROR_FLAG 0
`define RFE_B_PTE_WR 1
`define RFE_B_SVPC_OK 2

`define RFE_B_MCHK_EN 0
`define RFE_B_RETRY_EN 1
`define RFE_CTRL_RST 32'h00000003

`define RFE_HARD_IPL 5'h1D
`define RFE_HARD_VEC 8'h60
`define RFE_SOFT_IPL 5'h1A
`define RFE_SOFT_VEC 8'h54

`endif

/* verilog/rfe_pkg.sv */
// Purpose: Types shared by the error logging block and its helpers.
// Assumes: Widths come from rfe_defines.svh.
// Notes:   Structs carry one event with its details.
`include "rfe_defines.svh"

package rfe_pkg;

	typedef enum logic [2:0] {
		RFE_PTE_IDLE = 3'b001,
		RFE_PTE_PROBE = 3'b010,
		RFE_PTE_REPORT = 3'b100
	} rfe_pte_state_t;

	typedef enum logic [1:0] {
		RFE_OP_BLOCK_READ = 2'h0,
		RFE_OP_LOAD_LOCKED = 2'h1,
		RFE_OP_WRITE_MERGE = 2'h2
	} rfe_fill_op_t;

	typedef struct packed {
		logic [`RFE_ADDR_W-1:0] addr;
		logic [`RFE_SYN_W-1:0] synd;
		rfe_fill_op_t op;
		logic multibit;
	} rfe_fill_ev_t;

	typedef struct packed {
		logic cack;
		logic tpar;
		logic tcpar;
		logic istream;
		logic ownership;
	} rfe_rd_ev_t;

endpackage : rfe_pkg

/* verilog/rfe_err_latch.sv */
// Purpose: First-error capture with a second-error flag.
// Assumes: ev and clr are one-cycle pulses on CLK.
// Notes:   A new event beats a clear in the same cycle.
`timescale 1ns/1ns

module rfe_err_latch #(
	parameter int W = 8
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic ev,
	input wire logic [W-1:0] din,
	input wire logic clr,
	input wire logic clr_seo,
	output logic valid_ff,
	output logic seo_ff,
	output logic [W-1:0] data_ff
);

	logic armed;

	// A clear in the same cycle re-arms, so the new event is captured
	assign armed = !valid_ff || clr;

	always_ff @(posedge CLK) begin
		if (!RSTN)
			valid_ff <= 1'b0;
		else if (ev)
			valid_ff <= 1'b1;
		else if (clr)
			valid_ff <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			data_ff <= '0;
		else if (ev && armed)
			data_ff <= din;
	end

	// Details of the later error are dropped; only its presence is kept
	always_ff @(posedge CLK) begin
		if (!RSTN)
			seo_ff <= 1'b0;
		else if (ev && !armed)
			seo_ff <= 1'b1;
		else if (clr_seo)
			seo_ff <= 1'b0;
	end

endmodule : rfe_err_latch

/* verilog/rfe_mchk_arb.sv */
// Purpose: Holds erroneous stream reads until the pipeline uses them.
// Assumes: Pipeline use strobes are one-cycle pulses.
// Notes:   A flush turns pending errors into soft-only reports.
`timescale 1ns/1ns

module rfe_mchk_arb (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic ev,
	input wire logic ev_istream,
	input wire logic ev_own,
	input wire logic i_dispatch,
	input wire logic i_operand,
	input wire logic d_operand,
	input wire logic err_data_ret,
	input wire logic flush,
	output logic hit
);

	logic i_pend_ff;
	logic d_pend_ff;
	logic own_pend_ff;
	logic done;

	assign hit = (i_pend_ff && (i_dispatch || i_operand)) ||
		(d_pend_ff && (d_operand || err_data_ret)) ||
		(own_pend_ff && d_operand);
	assign done = hit || flush;

	always_ff @(posedge CLK) begin
		if (!RSTN)
			i_pend_ff <= 1'b0;
		else if (ev && ev_istream)
			i_pend_ff <= 1'b1;
		else if (done)
			i_pend_ff <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			d_pend_ff <= 1'b0;
		else if (ev && !ev_istream && !ev_own)
			d_pend_ff <= 1'b1;
		else if (done)
			d_pend_ff <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			own_pend_ff <= 1'b0;
		else if (ev && !ev_istream && ev_own)
			own_pend_ff <= 1'b1;
		else if (done)
			own_pend_ff <= 1'b0;
	end

endmodule : rfe_mchk_arb

/* verilog/rfe_error_log.sv */
// Purpose: Read and fill error logging, machine check decision and
//          stack frame capture, with an APB register file.
// Assumes: All inputs synchronous to CLK; event inputs are pulses.
// Notes:   One wait state on every APB access.
`timescale 1ns/1ns
`include "rfe_defines.svh"

module rfe_error_log (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`RFE_PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic PREADY,
	output logic [31:0] PRDATA,
	output logic PSLVERR,
	input wire logic FILL_ERR,
	input wire rfe_pkg::rfe_fill_ev_t FILL_INFO,
	input wire logic READ_ERR,
	input wire rfe_pkg::rfe_rd_ev_t READ_INFO,
	input wire logic I_DISPATCH,
	input wire logic I_OPERAND,
	input wire logic D_OPERAND,
	input wire logic ERR_DATA_RETURN,
	input wire logic PIPE_FLUSH,
	input wire logic PTE_ERR,
	input wire logic PTE_REF_WRITE,
	input wire logic PTE_REF_EXEC,
	input wire logic PROBE_DONE,
	input wire logic PROBE_FAIL,
	input wire logic STRING_INSTR,
	input wire logic [`RFE_PC_W-1:0] CUR_PC,
	input wire logic [`RFE_PC_W-1:0] NEXT_PC,
	output logic MCHK,
	output logic ABORT_TB_MISS,
	output logic FORCE_MM_FAULT,
	output logic RESTART_ISTREAM,
	output logic [`RFE_PC_W-1:0] FRAME_PC,
	output logic [`RFE_PC_W-1:0] FRAME_SAVED_PC,
	output logic FRAME_SAVED_PC_VALID,
	output logic HARD_ERR_REQ,
	output logic SOFT_ERR_REQ,
	output logic [4:0] INT_IPL,
	output logic [7:0] INT_VEC
);

	localparam int FW = $bits(rfe_pkg::rfe_fill_ev_t);
	localparam int RW = $bits(rfe_pkg::rfe_rd_ev_t);

	rfe_pkg::rfe_pte_state_t pte_ff;
	rfe_pkg::rfe_pte_state_t nxt_pte;
	rfe_pkg::rfe_fill_ev_t fill_q;
	rfe_pkg::rfe_rd_ev_t rd_q;
	logic [FW-1:0] fill_raw;
	logic [RW-1:0] rd_raw;
	logic fill_val;
	logic fill_second_error_flag;
	logic rd_val;
	logic rd_seo;
	logic fill_unc;
	logic fill_rd;
	logic wr_lost_ff;
	logic page_entry_read_error_flag_ff;
	logic pte_wr_ff;
	logic [31:0] ctrl_ff;
	logic pready_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic wr_en;
	logic rd_en;
	logic [31:0] status;
	logic [31:0] pcs;
	logic [31:0] rdata;
	logic mapped;
	logic stream_hit;
	logic pte_mchk;
	logic mchk_en;
	logic retry_en;
	logic clr_fill;
	logic clr_fill_second_error_flag;
	logic clr_rd;
	logic clr_rd_seo;
	logic clr_wr_lost;
	logic clr_page_entry_read_error_flag;
	logic clr_pte_wr;
	logic pte_str_ff;
	logic mchk_ff;
	logic abort_ff;
	logic force_ff;
	logic restart_ff;
	logic [`RFE_PC_W-1:0] frame_pc_ff;
	logic [`RFE_PC_W-1:0] frame_svpc_ff;
	logic frame_ok_ff;
	logic hard_ff;
	logic soft_ff;
	logic [4:0] ipl_ff;
	logic [7:0] vec_ff;
	logic hard_cond;
	logic soft_cond;

	// APB: access completes one cycle after the access phase starts
	assign wr_en = PSEL && PENABLE && pready_ff && PWRITE;
	assign rd_en = PSEL && PENABLE && !pready_ff && !PWRITE;
	assign mchk_en = ctrl_ff[`RFE_B_MCHK_EN];
	assign retry_en = ctrl_ff[`RFE_B_RETRY_EN];

	// Status clears are write-one-to-clear
	assign clr_fill = wr_en && PADDR == `RFE_OFF_STATUS &&
		PWDATA[`RFE_B_FILL_VAL];
	assign clr_fill_second_error_flag = wr_en && PADDR == `RFE_OFF_STATUS &&
		PWDATA[`RFE_B_FILL_SECOND_ERROR_FLAG];
	assign clr_rd = wr_en && PADDR == `RFE_OFF_STATUS &&
		PWDATA[`RFE_B_RDHERR];
	assign clr_rd_seo = wr_en && PADDR == `RFE_OFF_STATUS &&
		PWDATA[`RFE_B_BUS_SEO];
	assign clr_wr_lost = wr_en && PADDR == `RFE_OFF_STATUS &&
		PWDATA[`RFE_B_WR_LOST];
	assign clr_page_entry_read_error_flag = wr_en && PADDR == `RFE_OFF_PCS &&
		PWDATA[`RFE_B_PAGE_ENTRY_READ_ERROR_FLAG];
	assign clr_pte_wr = wr_en && PADDR == `RFE_OFF_PCS &&
		PWDATA[`RFE_B_PTE_WR];

	assign fill_raw = FILL_INFO;
	assign rd_raw = READ_INFO;

	rfe_err_latch #(
		.W(FW)
	) u_fill (
		.CLK(CLK),
		.RSTN(RSTN),
		.ev(FILL_ERR),
		.din(fill_raw),
		.clr(clr_fill),
		.clr_seo(clr_fill_second_error_flag),
		.valid_ff(fill_val),
		.seo_ff(fill_second_error_flag),
		.data_ff(fill_q)
	);

	rfe_err_latch #(
		.W(RW)
	) u_read (
		.CLK(CLK),
		.RSTN(RSTN),
		.ev(READ_ERR),
		.din(rd_raw),
		.clr(clr_rd),
		.clr_seo(clr_rd_seo),
		.valid_ff(rd_val),
		.seo_ff(rd_seo),
		.data_ff(rd_q)
	);

	rfe_mchk_arb u_arb (
		.CLK(CLK),
		.RSTN(RSTN),
		.ev(READ_ERR),
		.ev_istream(READ_INFO.istream),
		.ev_own(READ_INFO.ownership),
		.i_dispatch(I_DISPATCH),
		.i_operand(I_OPERAND),
		.d_operand(D_OPERAND),
		.err_data_ret(ERR_DATA_RETURN),
		.flush(PIPE_FLUSH),
		.hit(stream_hit)
	);

	// Any multiple-bit fill error is uncorrectable, whatever the op
	assign fill_unc = fill_q.multibit;
	assign fill_rd = fill_q.op != rfe_pkg::RFE_OP_WRITE_MERGE;

	// Merged write data is gone once its fill fails
	always_ff @(posedge CLK) begin
		if (!RSTN)
			wr_lost_ff <= 1'b0;
		else if (FILL_ERR &&
			FILL_INFO.op == rfe_pkg::RFE_OP_WRITE_MERGE)
			wr_lost_ff <= 1'b1;
		else if (clr_wr_lost)
			wr_lost_ff <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			page_entry_read_error_flag_ff <= 1'b0;
		else if (PTE_ERR)
			page_entry_read_error_flag_ff <= 1'b1;
		else if (clr_page_entry_read_error_flag)
			page_entry_read_error_flag_ff <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			pte_wr_ff <= 1'b0;
		else if (PTE_ERR && PTE_REF_WRITE)
			pte_wr_ff <= 1'b1;
		else if (clr_pte_wr)
			pte_wr_ff <= 1'b0;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			ctrl_ff <= `RFE_CTRL_RST;
		else if (wr_en && PADDR == `RFE_OFF_CTRL)
			ctrl_ff <= PWDATA & 32'h00000003;
	end

	// Page entry error sequence for execution-unit references
	always_comb begin
		nxt_pte = pte_ff;
		case (pte_ff)
			rfe_pkg::RFE_PTE_IDLE: begin
				if (PTE_ERR && PTE_REF_EXEC)
					nxt_pte = retry_en ? rfe_pkg::RFE_PTE_PROBE :
						rfe_pkg::RFE_PTE_REPORT;
			end
			rfe_pkg::RFE_PTE_PROBE: begin
				if (PROBE_DONE)
					nxt_pte = PROBE_FAIL ? rfe_pkg::RFE_PTE_REPORT :
						rfe_pkg::RFE_PTE_IDLE;
			end
			rfe_pkg::RFE_PTE_REPORT: begin
				nxt_pte = rfe_pkg::RFE_PTE_IDLE;
			end
			default: begin
				nxt_pte = rfe_pkg::RFE_PTE_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			pte_ff <= rfe_pkg::RFE_PTE_IDLE;
		else
			pte_ff <= nxt_pte;
	end

	// String instruction status is taken with the original error
	always_ff @(posedge CLK) begin
		if (!RSTN)
			pte_str_ff <= 1'b0;
		else if (PTE_ERR && pte_ff == rfe_pkg::RFE_PTE_IDLE)
			pte_str_ff <= STRING_INSTR && PTE_REF_EXEC;
	end

	assign pte_mchk = pte_ff == rfe_pkg::RFE_PTE_REPORT;

	always_ff @(posedge CLK) begin
		if (!RSTN)
			abort_ff <= 1'b0;
		else
			abort_ff <= PTE_ERR;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			force_ff <= 1'b0;
		else
			force_ff <= pte_ff == rfe_pkg::RFE_PTE_IDLE && PTE_ERR &&
				PTE_REF_EXEC && retry_en;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			restart_ff <= 1'b0;
		else
			restart_ff <= pte_ff == rfe_pkg::RFE_PTE_PROBE &&
				PROBE_DONE && !PROBE_FAIL;
	end

	// Disabled machine checks leave the soft report as the only notice
	always_ff @(posedge CLK) begin
		if (!RSTN)
			mchk_ff <= 1'b0;
		else
			mchk_ff <= mchk_en && (stream_hit || pte_mchk);
	end

	// Stack frame values taken at the machine check
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			frame_pc_ff <= '0;
			frame_svpc_ff <= '0;
			frame_ok_ff <= 1'b0;
		end else if (mchk_en && pte_mchk && pte_str_ff) begin
			frame_pc_ff <= NEXT_PC;
			frame_svpc_ff <= CUR_PC;
			frame_ok_ff <= 1'b1;
		end else if (mchk_en && (stream_hit || pte_mchk)) begin
			frame_pc_ff <= CUR_PC;
			frame_svpc_ff <= '0;
			frame_ok_ff <= 1'b0;
		end
	end

	// Interrupt requests follow the held flags
	assign hard_cond = wr_lost_ff ||
		(fill_val && fill_unc);
	assign soft_cond = rd_val || rd_seo || fill_second_error_flag || page_entry_read_error_flag_ff ||
		(fill_val && !fill_unc);

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			hard_ff <= 1'b0;
			soft_ff <= 1'b0;
			ipl_ff <= 5'h00;
			vec_ff <= 8'h00;
		end else begin
			hard_ff <= hard_cond;
			soft_ff <= soft_cond;
			if (hard_cond) begin
				ipl_ff <= `RFE_HARD_IPL;
				vec_ff <= `RFE_HARD_VEC;
			end else if (soft_cond) begin
				ipl_ff <= `RFE_SOFT_IPL;
				vec_ff <= `RFE_SOFT_VEC;
			end else begin
				ipl_ff <= 5'h00;
				vec_ff <= 8'h00;
			end
		end
	end

	// Read side of the register file
	always_comb begin
		status = 32'h00000000;
		status[`RFE_B_RDHERR] = rd_val;
		status[`RFE_B_TPAR] = rd_val && rd_q.tpar;
		status[`RFE_B_TCPAR] = rd_val && rd_q.tcpar;
		status[`RFE_B_CACK] = rd_val && rd_q.cack;
		status[`RFE_B_ISTR] = rd_val && rd_q.istream;
		status[`RFE_B_BUS_SEO] = rd_seo;
		status[`RFE_B_FILL_VAL] = fill_val;
		status[`RFE_B_FILL_UNC] = fill_val && fill_unc;
		status[`RFE_B_FILL_RD] = fill_val && fill_rd;
		status[`RFE_B_FILL_SECOND_ERROR_FLAG] = fill_second_error_flag;
		status[`RFE_B_WR_LOST] = wr_lost_ff;
		pcs = 32'h00000000;
		pcs[`RFE_B_PAGE_ENTRY_READ_ERROR_FLAG] = page_entry_read_error_flag_ff;
		pcs[`RFE_B_PTE_WR] = pte_wr_ff;
		pcs[`RFE_B_SVPC_OK] = frame_ok_ff;
		mapped = 1'b1;
		case (PADDR)
			`RFE_OFF_STATUS: rdata = status;
			`RFE_OFF_FADDR: rdata = fill_q.addr;
			`RFE_OFF_FSYN: rdata = {24'h000000, fill_q.synd};
			`RFE_OFF_PCS: rdata = pcs;
			`RFE_OFF_CTRL: rdata = ctrl_ff;
			`RFE_OFF_FRPC: rdata = frame_pc_ff;
			`RFE_OFF_SVPC: rdata = frame_svpc_ff;
			default: begin
				rdata = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			pready_ff <= 1'b0;
		else
			pready_ff <= PSEL && PENABLE && !pready_ff;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else if (PSEL && PENABLE && !pready_ff) begin
			prdata_ff <= rd_en ? rdata : 32'h00000000;
			pslverr_ff <= !mapped;
		end else begin
			pslverr_ff <= 1'b0;
		end
	end

	assign PREADY = pready_ff;
	assign PRDATA = prdata_ff;
	assign PSLVERR = pslverr_ff;
	assign MCHK = mchk_ff;
	assign ABORT_TB_MISS = abort_ff;
	assign FORCE_MM_FAULT = force_ff;
	assign RESTART_ISTREAM = restart_ff;
	assign FRAME_PC = frame_pc_ff;
	assign FRAME_SAVED_PC = frame_svpc_ff;
	assign FRAME_SAVED_PC_VALID = frame_ok_ff;
	assign HARD_ERR_REQ = hard_ff;
	assign SOFT_ERR_REQ = soft_ff;
	assign INT_IPL = ipl_ff;
	assign INT_VEC = vec_ff;

endmodule : rfe_error_log

/* tb/rfe_error_log_checker.sv */
// Purpose: Port-level assertions for the error logging block.
// Assumes: No failing probe is answered while traps are disabled.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/1ns
`include "rfe_defines.svh"

module rfe_checker (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic I_DISPATCH,
	input wire logic I_OPERAND,
	input wire logic D_OPERAND,
	input wire logic ERR_DATA_RETURN,
	input wire logic FILL_ERR,
	input wire logic PTE_ERR,
	input wire logic PTE_REF_EXEC,
	input wire logic PROBE_DONE,
	input wire logic PROBE_FAIL,
	input wire logic [`RFE_PC_W-1:0] CUR_PC,
	input wire logic MCHK,
	input wire logic ABORT_TB_MISS,
	input wire logic FORCE_MM_FAULT,
	input wire logic RESTART_ISTREAM,
	input wire logic [`RFE_PC_W-1:0] FRAME_PC,
	input wire logic FRAME_SAVED_PC_VALID,
	input wire logic HARD_ERR_REQ,
	input wire logic SOFT_ERR_REQ,
	input wire logic [4:0] INT_IPL,
	input wire logic [7:0] INT_VEC
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY
		&& !PSLVERR || PREADY && PSLVERR)
		else $error("no answer one cycle into the access phase");
	pte_abort_a: assert property (PTE_ERR |=> ABORT_TB_MISS)
		else $error("page entry error did not abort the miss");
	mm_fault_a: assert property (FORCE_MM_FAULT |-> ABORT_TB_MISS
		&& $past(PTE_ERR && PTE_REF_EXEC))
		else $error("fault routine forced without execution reference");
	restart_a: assert property (PROBE_DONE && !PROBE_FAIL
		|=> RESTART_ISTREAM && !MCHK)
		else $error("good probe did not restart the stream");
	probe_mchk_a: assert property (PROBE_DONE && PROBE_FAIL |-> ##2 MCHK)
		else $error("failed probe did not trap");
	mchk_cause_a: assert property (MCHK |->
		$past(I_DISPATCH || I_OPERAND || D_OPERAND || ERR_DATA_RETURN)
		|| $past(PROBE_DONE, 2) || $past(PTE_ERR, 2))
		else $error("machine check without a pipeline cause");
	hard_src_a: assert property ($rose(HARD_ERR_REQ) |->
		$past(FILL_ERR, 2))
		else $error("hard request not caused by a fill error");
	ipl_hard_a: assert property (HARD_ERR_REQ |->
		INT_IPL == 5'h1D && INT_VEC == 8'h60)
		else $error("wrong level or vector for hard request");
	ipl_soft_a: assert property (SOFT_ERR_REQ && !HARD_ERR_REQ |->
		INT_IPL == 5'h1A && INT_VEC == 8'h54)
		else $error("wrong level or vector for soft request");
	frame_plain_a: assert property (MCHK && $past(I_DISPATCH) |->
		!FRAME_SAVED_PC_VALID && FRAME_PC == $past(CUR_PC))
		else $error("stream trap frame wrong");

	cover property (MCHK && FRAME_SAVED_PC_VALID);
	cover property (RESTART_ISTREAM);
	cover property (PSLVERR);
endmodule : rfe_checker

/* tb/rfe_cache_model.sv */
// Purpose: Cache controller stand-in: error reports and probe answers.
// Assumes: Bench calls the tasks; probe latency and outcome are knobs.
// Notes: Detail buses carry inverted junk outside their pulse.
`timescale 1ns/1ns

module rfe_cache_model (
	input wire logic CLK,
	input wire logic FORCE_MM_FAULT,
	output rfe_pkg::rfe_fill_ev_t FILL_INFO,
	output logic FILL_ERR,
	output rfe_pkg::rfe_rd_ev_t READ_INFO,
	output logic READ_ERR,
	output logic PROBE_DONE,
	output logic PROBE_FAIL
);
	int lat = 1;
	logic fail_next = 1'h1;

	task send_fill(input rfe_pkg::rfe_fill_ev_t i);
		@(posedge CLK);
		FILL_ERR <= 1'h1;
		FILL_INFO <= i;
		@(posedge CLK);
		FILL_ERR <= 1'h0;
		FILL_INFO <= ~i;
	endtask : send_fill

	task send_read(input rfe_pkg::rfe_rd_ev_t i);
		@(posedge CLK);
		READ_ERR <= 1'h1;
		READ_INFO <= i;
		@(posedge CLK);
		READ_ERR <= 1'h0;
		READ_INFO <= ~i;
	endtask : send_read

	// The probe repeats the failing entry read; fail_next says if it fails
	initial begin
		FILL_ERR = 1'h0;
		READ_ERR = 1'h0;
		FILL_INFO = '0;
		READ_INFO = '0;
		PROBE_DONE = 1'h0;
		PROBE_FAIL = 1'h0;
		forever begin
			@(posedge CLK);
			if (FORCE_MM_FAULT === 1'h1) begin
				repeat (lat) @(posedge CLK);
				PROBE_DONE <= 1'h1;
				PROBE_FAIL <= fail_next;
				@(posedge CLK);
				PROBE_DONE <= 1'h0;
				PROBE_FAIL <= ~fail_next;
			end
		end
	end
endmodule : rfe_cache_model

/* tb/read_fill_error_logging_bench.sv */
// Purpose: Self-checking bench for the error logging block.
// Assumes: Pipeline strobes and page entry errors are driven here, read and fill error reports by the model.
// Notes: Reads and traps are checked from queues by a monitor.
`timescale 1ns/1ns

module read_fill_error_logging_bench;
	logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0] PADDR, INT_VEC;
	logic [31:0] PWDATA, PRDATA, CUR_PC, NEXT_PC, FRAME_PC, FRAME_SAVED_PC;
	logic [4:0] INT_IPL;
	logic I_DISPATCH, I_OPERAND, D_OPERAND, ERR_DATA_RETURN, PIPE_FLUSH;
	logic PTE_ERR, PTE_REF_WRITE, PTE_REF_EXEC, STRING_INSTR, MCHK;
	logic ABORT_TB_MISS, FORCE_MM_FAULT, RESTART_ISTREAM;
	logic FRAME_SAVED_PC_VALID, HARD_ERR_REQ, SOFT_ERR_REQ;
	logic FILL_ERR, READ_ERR, PROBE_DONE, PROBE_FAIL;
	rfe_pkg::rfe_fill_ev_t FILL_INFO;
	rfe_pkg::rfe_rd_ev_t READ_INFO;
	logic [32:0] rdq[$];
	logic [64:0] mcq[$];
	int errors = 0;
	int n_tests = 0;
	logic [31:0] rs = 32'h0000C5F1;
	logic [31:0] fa;
	logic [7:0] fs;
	logic [4:0] ri[3] = '{5'h12, 5'h08, 5'h04};
	logic [31:0] re[3] = '{32'h19, 32'h03, 32'h05};
	logic [4:0] mi[4] = '{5'h12, 5'h12, 5'h10, 5'h11};
	logic [4:0] mw[4] = '{5'h02, 5'h02, 5'h00, 5'h02};
	logic [4:0] mr[4] = '{5'h10, 5'h08, 5'h02, 5'h04};

	rfe_error_log DUT (.*);
	rfe_cache_model PART (.*);

	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs

	task cmp(input string nm, input logic [64:0] ex, input logic [64:0] got);
		n_tests++;
		if (got !== ex) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask : cmp

	task end_of_test();
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		n = 0;
		if (!w)
			rdq.push_back(e);
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'h1 && n < 20);
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		if (n >= 20) begin
			errors++;
			end_of_test();
		end
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'h0, a, 32'h0, {1'h0, d});
	endtask : rd

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d, 33'h0);
	endtask : wr

	task pulse(input logic [4:0] v);
		@(posedge CLK);
		{I_DISPATCH, I_OPERAND, D_OPERAND, ERR_DATA_RETURN, PIPE_FLUSH} <= v;
		@(posedge CLK);
		{I_DISPATCH, I_OPERAND, D_OPERAND, ERR_DATA_RETURN, PIPE_FLUSH} <= '0;
	endtask : pulse

	task pte(input logic w, input logic e, input logic s);
		@(posedge CLK);
		PTE_ERR <= 1'h1;
		PTE_REF_WRITE <= w;
		PTE_REF_EXEC <= e;
		STRING_INSTR <= s;
		@(posedge CLK);
		PTE_ERR <= 1'h0;
	endtask : pte

	task wait_mc();
		int n;
		n = 0;
		while (mcq.size() != 0 && n < 30) begin
			@(posedge CLK);
			n++;
		end
		if (mcq.size() != 0) begin
			errors++;
			end_of_test();
		end
	endtask : wait_mc

	task irq(input logic [14:0] ex);
		cmp("irq", {50'h0, ex},
			{50'h0, HARD_ERR_REQ, SOFT_ERR_REQ, INT_IPL, INT_VEC});
	endtask : irq

	// Saved PC is only compared when the expected frame marks it valid
	always @(posedge CLK) begin
		logic [64:0] e;
		logic [64:0] g;
		if (PREADY === 1'h1 && PWRITE === 1'h0 && rdq.size() != 0)
			cmp("read", {32'h0, rdq.pop_front()}, {32'h0, PSLVERR, PRDATA});
		if (MCHK === 1'h1) begin
			e = (mcq.size() != 0) ? mcq.pop_front() : '1;
			g = {FRAME_SAVED_PC_VALID, FRAME_SAVED_PC, FRAME_PC};
			if (e[64] === 1'h0)
				g[63:32] = e[63:32];
			cmp("frame", e, g);
		end
	end

	initial begin
		CLK = 1'h0;
		forever #10 CLK = ~CLK;
	end

	initial begin
		int n;
		{RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{I_DISPATCH, I_OPERAND, D_OPERAND, ERR_DATA_RETURN, PIPE_FLUSH} = '0;
		{PTE_ERR, PTE_REF_WRITE, PTE_REF_EXEC, STRING_INSTR} = '0;
		CUR_PC = 32'h0;
		NEXT_PC = 32'h0;
		repeat (4) @(posedge CLK);
		RSTN <= 1'h1;
		rd(8'h10, 32'h3);
		rd(8'h00, 32'h0);
		apb(1'h0, 8'h1C, 32'h0, {1'h1, 32'h0});
		fa = xs();
		fs = 8'(xs());
		PART.send_fill('{fa, fs, rfe_pkg::RFE_OP_BLOCK_READ, 1'h1});
		rd(8'h00, 32'h700);
		rd(8'h04, fa);
		rd(8'h08, {24'h0, fs});
		irq({2'h2, 5'h1D, 8'h60});
		PART.send_fill('{~fa, ~fs, rfe_pkg::RFE_OP_LOAD_LOCKED, 1'h1});
		wr(8'h04, ~fa);
		rd(8'h00, 32'h4700);
		rd(8'h04, fa);
		wr(8'h00, 32'h4700);
		PART.send_fill('{~fa, fs, rfe_pkg::RFE_OP_WRITE_MERGE, 1'h0});
		rd(8'h00, 32'h100100);
		rd(8'h04, ~fa);
		irq({2'h3, 5'h1D, 8'h60});
		wr(8'h00, 32'h100100);
		for (int k = 0; k < 3; k++) begin
			PART.send_read(ri[k]);
			rd(8'h00, re[k]);
			irq({2'h1, 5'h1A, 8'h54});
			pulse(5'h01);
			wr(8'h00, 32'h9F);
		end
		PART.send_read(5'h10);
		PART.send_read(5'h10);
		rd(8'h00, 32'h89);
		pulse(5'h01);
		wr(8'h00, 32'h9F);
		CUR_PC <= xs();
		NEXT_PC <= xs();
		for (int k = 0; k < 4; k++) begin
			PART.send_read(mi[k]);
			pulse(mw[k]);
			repeat (3) @(posedge CLK);
			mcq.push_back({1'h0, 32'h0, CUR_PC});
			pulse(mr[k]);
			wait_mc();
			wr(8'h00, 32'h9F);
		end
		wr(8'h10, 32'h2);
		rd(8'h10, 32'h2);
		PART.send_read(5'h12);
		pulse(5'h10);
		repeat (3) @(posedge CLK);
		wr(8'h00, 32'h9F);
		wr(8'h10, 32'h1);
		mcq.push_back({1'h0, 32'h0, CUR_PC});
		pte(1'h0, 1'h1, 1'h0);
		wait_mc();
		wr(8'h0C, 32'h3);
		wr(8'h10, 32'h3);
		pte(1'h1, 1'h0, 1'h0);
		rd(8'h0C, 32'h3);
		wr(8'h0C, 32'h3);
		PART.lat = 5;
		PART.fail_next = 1'h0;
		pte(1'h0, 1'h1, 1'h1);
		n = 0;
		while (RESTART_ISTREAM !== 1'h1 && n < 30) begin
			@(posedge CLK);
			n++;
		end
		cmp("restart", 65'h1, {64'h0, RESTART_ISTREAM});
		rd(8'h0C, 32'h1);
		wr(8'h0C, 32'h3);
		PART.lat = 1;
		PART.fail_next = 1'h1;
		mcq.push_back({1'h1, CUR_PC, NEXT_PC});
		pte(1'h0, 1'h1, 1'h1);
		wait_mc();
		rd(8'h0C, 32'h5);
		end_of_test();
	end
endmodule : read_fill_error_logging_bench

bind rfe_error_log rfe_checker CHK (.CLK, .RSTN, .PSEL, .PENABLE,
	.PREADY, .PSLVERR, .I_DISPATCH, .I_OPERAND, .D_OPERAND,
	.ERR_DATA_RETURN, .FILL_ERR, .PTE_ERR, .PTE_REF_EXEC, .PROBE_DONE,
	.PROBE_FAIL, .CUR_PC, .MCHK, .ABORT_TB_MISS, .FORCE_MM_FAULT,
	.RESTART_ISTREAM, .FRAME_PC, .FRAME_SAVED_PC_VALID, .HARD_ERR_REQ,
	.SOFT_ERR_REQ, .INT_IPL, .INT_VEC);
